//--- rtl/pcr_regs.vh
// Purpose: Constants of the power controller configuration register bank.
// Assumes: Included by the register bank and its serial target.
// Notes: Offsets are the serial register addresses; values are eight bits wide.
`ifndef PCR_REGS_VH
`define PCR_REGS_VH
`define PCR_TARGET_ADDR 7'h2d
`define PCR_OFF_CONV_EN 8'h01
`define PCR_OFF_AUX_VOLT 8'h10
`define PCR_OFF_CH1_VOLT 8'h11
`define PCR_OFF_CH2_VOLT 8'h12
`define PCR_OFF_CH3_VOLT 8'h13
`define PCR_OFF_CH4_VOLT 8'h14
`define PCR_OFF_GROUP 8'h15
`define PCR_OFF_AUX_EN 8'h16
`define PCR_OFF_GOOD1 8'h17
`define PCR_OFF_GOOD2 8'h18
`define PCR_OFF_FAULT 8'h19
`define PCR_OFF_HEALTH 8'h1a
`define PCR_OFF_TEMP 8'h1b
`define PCR_OFF_AIN0 8'h1c
`define PCR_OFF_AIN1 8'h1d
`define PCR_RST_CONV_EN 8'h01
`define PCR_RST_AUX_VOLT 8'ha5
`define PCR_RST_ZERO 8'h00
`define PCR_RST_FAULT 8'h20
`define PCR_MASK_CONV_EN 8'h01
`define PCR_MASK_AUX_EN 8'hdf
`define PCR_MASK_GOOD1 8'hdf
`define PCR_MASK_GOOD2 8'h1f
`define PCR_MASK_FAULT 8'hef
`define PCR_SWITCHING_RATE_CODE_LSB 0
`define PCR_SWITCHING_RATE_CODE_MSB 3
`define PCR_DISCHARGE_BIT 5
`define PCR_SOFTOFF_BIT 6
`define PCR_FAULTSEL_BIT 7
`define PCR_HOLD_US 2200
`define PCR_CLK_MHZ 200
`define PCR_HOLD_CYCLES (`PCR_HOLD_US * `PCR_CLK_MHZ)
`endif

//--- rtl/pcr_i2c_target.v
// Purpose: Serial target front end; turns bus frames into register reads and writes.
// Assumes: Scl and sda are already synchronised to mclk by the caller.
// Notes: Never holds scl low; a refused byte is answered with a missing acknowledge.
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_i2c_target (
    input wire mclk,
    input wire resetn,
    input wire scl_s,
    input wire sda_s,
    output reg sda_oe_q,
    output reg [7:0] wr_addr_q,
    output reg [7:0] wr_data_q,
    output reg wr_stb_q,
    input wire wr_ok,
    output reg [7:0] rd_addr_q,
    input wire [7:0] rd_data
);
    // Frame phases.
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_REG = 3'd2;
    localparam ST_WDAT = 3'd3;
    localparam ST_RDAT = 3'd4;
    localparam ST_RACK = 3'd5;
    localparam ST_SKIP = 3'd6;

    reg scl_q; // Previous scl level for edge detection.
    reg sda_q; // Previous sda level for start and stop detection.
    reg [2:0] st_q; // Current frame phase.
    reg [3:0] bit_q; // Bit count within a byte; 8 marks the acknowledge slot.
    reg [7:0] sh_q; // Shift register for incoming and outgoing bytes.
    reg ack_q; // Never set and never read; only cleared at reset and at a start.
    reg first_q; // High while the next read byte is still to be loaded from rd_data.
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c = scl_s & scl_q & ~sda_q & sda_s;

    // Bus sequencer; data is sampled on scl rising and driven after scl falling.
    always @(posedge mclk) begin
        scl_q <= scl_s;
        sda_q <= sda_s;
        wr_stb_q <= 1'b0;
        if (!resetn) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            rd_addr_q <= 8'h00;
            first_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (start_c) begin
            // A start or repeated start always reopens address reception.
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (scl_rise && st_q != ST_IDLE && st_q != ST_SKIP && st_q != ST_RDAT) begin
            // While sending, the byte moves on scl falling only; a rising edge must not shift or count.
            if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                // Master nak after a read byte ends the read.
                if (st_q == ST_RACK && sda_s) begin
                    st_q <= ST_SKIP;
                end else if (st_q == ST_RACK) begin
                    st_q <= ST_RDAT;
                end
            end else begin
                sh_q <= {sh_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
            end
        end else if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (bit_q == 4'h8 && st_q == ST_ADDR) begin
                // Only the fixed target address is acknowledged. [R01]
                if (sh_q[7:1] == `PCR_TARGET_ADDR) begin
                    sda_oe_q <= 1'b1;
                    st_q <= sh_q[0] ? ST_RDAT : ST_REG;
                    // A read counts from zero now, since its acknowledge rise is not seen while sending.
                    bit_q <= sh_q[0] ? 4'h0 : 4'h8;
                    first_q <= 1'b1;
                end else begin
                    st_q <= ST_SKIP;
                end
            end else if (bit_q == 4'h8 && st_q == ST_REG) begin
                // Register pointer byte.
                sda_oe_q <= 1'b1;
                rd_addr_q <= sh_q;
                wr_addr_q <= sh_q;
                st_q <= ST_WDAT;
            end else if (bit_q == 4'h8 && st_q == ST_WDAT) begin
                // Data byte; refused writes get no acknowledge, never a held clock. [R09]
                sda_oe_q <= wr_ok;
                wr_data_q <= sh_q;
                wr_stb_q <= wr_ok;
                wr_addr_q <= rd_addr_q;
                rd_addr_q <= rd_addr_q + 8'h01;
                if (!wr_ok) begin
                    st_q <= ST_SKIP;
                end
            end else if (st_q == ST_RDAT && bit_q == 4'h0 && first_q) begin
                // Load the byte to send and put out its first bit.
                sh_q <= {rd_data[6:0], 1'b0};
                sda_oe_q <= ~rd_data[7];
                first_q <= 1'b0;
                bit_q <= 4'h1;
                rd_addr_q <= rd_addr_q + 8'h01;
            end else if (st_q == ST_RDAT && bit_q != 4'h0 && bit_q != 4'h8) begin
                sda_oe_q <= ~sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
            end else if (st_q == ST_RDAT && bit_q == 4'h8) begin
                // Release sda for the master acknowledge.
                st_q <= ST_RACK;
                first_q <= 1'b1;
            end
        end
        if (!resetn) begin
            wr_stb_q <= 1'b0;
        end
    end
endmodule

//--- rtl/pcr_bank.v
// Operation
// [R01] Answer only target address 2d hex.
// [R02] Runtime registers writable live, no commit.
// [R03] Group register holds four two-bit fields.
// [R04] Aux group bits 7:6, enables 4:0.
// [R05] Trigger assign, two power-good routing sets.
// [R06] Fault select, soft-off, discharge, rate code.
// [R07] Fault register resets to 20 hex.
// [R08] Host keeps rate code fixed while running.
// [R09] Refuse by missing acknowledge, never stretching.
// [R10] Refuse voltage rewrite within 2.2 ms.
// [R11] Unused bits ignore writes, read zero.
//
// Purpose: Configuration and status register bank of a multi-output power controller.
// Assumes: Serial pins arrive asynchronously; status inputs come from mclk logic.
// Notes: Every control output is taken straight from its register.
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_bank #(
    parameter HOLD_CYCLES = `PCR_HOLD_CYCLES
) (
    input wire mclk,
    input wire resetn,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [7:0] health_status,
    input wire [7:0] die_temp,
    input wire [7:0] ain0_result,
    input wire [7:0] ain1_result,
    output reg converter_on_q,
    output reg [7:0] aux_voltage_q,
    output reg [7:0] channel1_voltage_q,
    output reg [7:0] channel2_voltage_q,
    output reg [7:0] channel3_voltage_q,
    output reg [7:0] channel4_voltage_q,
    output reg [7:0] group_select_q,
    output reg [7:0] aux_group_on_q,
    output reg [7:0] good_pin_one_route_q,
    output reg [7:0] good_pin_two_route_q,
    output reg [7:0] fault_rate_q
);
    reg [1:0] scl_sync_q; // Two-stage synchroniser for scl.
    reg [1:0] sda_sync_q; // Two-stage synchroniser for sda.
    wire sda_oe_w; // Acknowledge or zero bit drive from the target.
    wire [7:0] wr_addr; // Register written this cycle.
    wire [7:0] wr_data; // Byte written this cycle.
    wire wr_stb; // One-cycle write strobe.
    wire [7:0] rd_addr; // Register being read.
    reg [7:0] rd_data; // Read mux output.
    reg wr_ok; // Low when the pending write must be refused.
    reg [23:0] hold_q [0:4]; // Per voltage register hold-off counters.

    // Open-drain pin: only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_w;

    // Pins cross into mclk through two flip-flops.
    always @(posedge mclk) begin
        if (!resetn) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
        end
    end

    pcr_i2c_target u_target (
        .mclk(mclk),
        .resetn(resetn),
        .scl_s(scl_sync_q[1]),
        .sda_s(sda_sync_q[1]),
        .sda_oe_q(sda_oe_w),
        .wr_addr_q(wr_addr),
        .wr_data_q(wr_data),
        .wr_stb_q(wr_stb),
        .wr_ok(wr_ok),
        .rd_addr_q(rd_addr),
        .rd_data(rd_data)
    );

    // Index of a voltage register, or 7 when the offset is not one.
    function [2:0] volt_index;
        input [7:0] a;
        begin
            if (a >= `PCR_OFF_AUX_VOLT && a <= `PCR_OFF_CH4_VOLT) begin
                volt_index = a[2:0];
            end else begin
                volt_index = 3'd7;
            end
        end
    endfunction

    // Refusal check for the byte being acknowledged; the pointer has not advanced yet.
    always @* begin
        wr_ok = 1'b1;
        if (volt_index(rd_addr) != 3'd7) begin
            wr_ok = (hold_q[volt_index(rd_addr)] == 24'h000000); // [R10]
        end
    end

    // Each voltage register starts its own 2.2 ms window when written.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_hold
            always @(posedge mclk) begin
                if (!resetn) begin
                    hold_q[gi] <= 24'h000000;
                end else if (wr_stb && volt_index(wr_addr) == gi) begin
                    hold_q[gi] <= HOLD_CYCLES[23:0]; // [R10]
                end else if (hold_q[gi] != 24'h000000) begin
                    hold_q[gi] <= hold_q[gi] - 24'h000001;
                end
            end
        end
    endgenerate

    // Register writes take effect at once; unused bits are masked off.
    always @(posedge mclk) begin
        if (!resetn) begin
            converter_on_q <= 1'b1;
            aux_voltage_q <= `PCR_RST_AUX_VOLT;
            channel1_voltage_q <= `PCR_RST_ZERO;
            channel2_voltage_q <= `PCR_RST_ZERO;
            channel3_voltage_q <= `PCR_RST_ZERO;
            channel4_voltage_q <= `PCR_RST_ZERO;
            group_select_q <= `PCR_RST_ZERO;
            aux_group_on_q <= `PCR_RST_ZERO;
            good_pin_one_route_q <= `PCR_RST_ZERO;
            good_pin_two_route_q <= `PCR_RST_ZERO;
            fault_rate_q <= `PCR_RST_FAULT; // [R07]
        end else if (wr_stb) begin
            // The rate code is stored whenever written; keeping it still while running is the host's duty. [R08]
            case (wr_addr) // [R02]
                `PCR_OFF_CONV_EN: converter_on_q <= wr_data[0]; // [R11]
                `PCR_OFF_AUX_VOLT: aux_voltage_q <= wr_data;
                `PCR_OFF_CH1_VOLT: channel1_voltage_q <= wr_data;
                `PCR_OFF_CH2_VOLT: channel2_voltage_q <= wr_data;
                `PCR_OFF_CH3_VOLT: channel3_voltage_q <= wr_data;
                `PCR_OFF_CH4_VOLT: channel4_voltage_q <= wr_data;
                `PCR_OFF_GROUP: group_select_q <= wr_data; // [R03]
                `PCR_OFF_AUX_EN: aux_group_on_q <= wr_data & `PCR_MASK_AUX_EN; // [R04] [R11]
                `PCR_OFF_GOOD1: good_pin_one_route_q <= wr_data & `PCR_MASK_GOOD1; // [R05] [R11]
                `PCR_OFF_GOOD2: good_pin_two_route_q <= wr_data & `PCR_MASK_GOOD2; // [R05] [R11]
                `PCR_OFF_FAULT: fault_rate_q <= wr_data & `PCR_MASK_FAULT; // [R06] [R11]
                default: begin
                    // Read-only and unmapped offsets ignore writes.
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero.
    always @* begin
        case (rd_addr)
            `PCR_OFF_CONV_EN: rd_data = {7'h00, converter_on_q}; // [R11]
            `PCR_OFF_AUX_VOLT: rd_data = aux_voltage_q;
            `PCR_OFF_CH1_VOLT: rd_data = channel1_voltage_q;
            `PCR_OFF_CH2_VOLT: rd_data = channel2_voltage_q;
            `PCR_OFF_CH3_VOLT: rd_data = channel3_voltage_q;
            `PCR_OFF_CH4_VOLT: rd_data = channel4_voltage_q;
            `PCR_OFF_GROUP: rd_data = group_select_q;
            `PCR_OFF_AUX_EN: rd_data = aux_group_on_q;
            `PCR_OFF_GOOD1: rd_data = good_pin_one_route_q;
            `PCR_OFF_GOOD2: rd_data = good_pin_two_route_q;
            `PCR_OFF_FAULT: rd_data = fault_rate_q;
            `PCR_OFF_HEALTH: rd_data = health_status;
            `PCR_OFF_TEMP: rd_data = die_temp;
            `PCR_OFF_AIN0: rd_data = ain0_result;
            `PCR_OFF_AIN1: rd_data = ain1_result;
            default: rd_data = 8'h00;
        endcase
    end
endmodule

//--- test/pcr_bank_checker.sv
// Purpose: Port checker for the configuration register bank.
// Assumes: Bound to pcr_bank; scl stays low for many mclk around an ack.
// Notes: Reset values are checked while reset is still applied.
`timescale 1ns/1ps
module pcr_bank_checker #(
    parameter int HOLD_CYCLES = 440000
) (
    input wire mclk,
    input wire resetn,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire converter_on_q,
    input wire [7:0] aux_voltage_q,
    input wire [7:0] channel1_voltage_q,
    input wire [7:0] channel2_voltage_q,
    input wire [7:0] channel3_voltage_q,
    input wire [7:0] channel4_voltage_q,
    input wire [7:0] group_select_q,
    input wire [7:0] aux_group_on_q,
    input wire [7:0] good_pin_one_route_q,
    input wire [7:0] good_pin_two_route_q,
    input wire [7:0] fault_rate_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // Cycles since channel three last changed; saturates so the first write passes.
    // Channel three is the register that the bench rewrites, so the hold check is really exercised.
    int hold_cnt;
    // Words grouped so that one change test covers a whole family.
    wire [47:0] cfg_w = {7'h00, converter_on_q, group_select_q, aux_group_on_q, good_pin_one_route_q,
        good_pin_two_route_q, fault_rate_q};
    wire [39:0] volt_w = {aux_voltage_q, channel1_voltage_q, channel2_voltage_q, channel3_voltage_q,
        channel4_voltage_q};
    // Restart on every change, so the gap between two accepted writes is measured.
    always @(posedge mclk) begin
        if (!resetn) begin
            hold_cnt <= HOLD_CYCLES;
        end else if ($changed(channel3_voltage_q)) begin
            hold_cnt <= 0;
        end else if (hold_cnt < HOLD_CYCLES) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    a_reset_vals: assert property (disable iff (1'h0) !resetn |=> !sda_oe && converter_on_q &&
        aux_voltage_q == 8'ha5 && fault_rate_q == 8'h20 && volt_w[31:0] == 32'h0 && cfg_w[39:8] == 32'h0)
        else $error("reset values wrong");
    a_sda_out_low: assert property (sda_out == 1'h0)
        else $error("sda driven high");
    a_unused_zero: assert property (!aux_group_on_q[5] && !good_pin_one_route_q[5] &&
        good_pin_two_route_q[7:5] == 3'h0 && !fault_rate_q[4])
        else $error("unused bit set");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved while scl high");
    a_cfg_on_ack: assert property ($changed(cfg_w) |-> sda_oe && !scl_in)
        else $error("config changed without ack");
    a_volt_on_ack: assert property ($changed(volt_w) |-> sda_oe && !scl_in)
        else $error("voltage changed without ack");
    a_volt_hold: assert property ($changed(channel3_voltage_q) |-> hold_cnt >= HOLD_CYCLES - 4)
        else $error("voltage rewritten too soon");
    a_ack_stands: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("ack dropped early");
    c_ack: cover property ($rose(sda_oe));
    c_volt: cover property ($changed(channel3_voltage_q));
    c_fault: cover property ($changed(fault_rate_q));
endmodule

//--- test/pcr_host.sv
// Purpose: Serial bus host that reads and writes the bank's registers.
// Assumes: Pull-up on sda; sda_low pulls the line down.
// Notes: Q mclk cycles per quarter bit; scl rests high between frames.
`timescale 1ns/1ps
module pcr_host #(
    parameter int Q = 16
) (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Idle bus with both lines released.
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // One quarter bit; every change lands just after a falling mclk edge.
    task automatic step(input logic c, input logic lo);
        scl = c;
        sda_low = lo;
        repeat (Q) @(negedge mclk);
    endtask
    // Start or repeated start: sda falls while scl is high.
    task automatic start();
        step(scl, 1'h0);
        step(1'h1, 1'h0);
        step(1'h1, 1'h1);
        step(1'h0, 1'h1);
    endtask
    // Stop leaves scl high, so the clock stands still outside frames.
    task automatic stop();
        step(1'h0, 1'h1);
        step(1'h1, 1'h1);
        step(1'h1, 1'h0);
    endtask
    // Nine bits msb first; sampled at a fixed time since scl is never stretched.
    task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic [8:0] s;
        logic lo;
        for (int i = 8; i >= 0; i--) begin
            lo = (i > 0) ? !b[i-1] : 1'h0;
            step(1'h0, lo);
            step(1'h1, lo);
            s[i] = sda;
            step(1'h1, lo);
            step(1'h0, lo);
        end
        r = s[8:1];
        ack = !s[0];
    endtask
    // Write one register; ok is set only when all three bytes were acknowledged.
    task automatic wr(input logic [6:0] a, input logic [7:0] rg, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0;
        logic k1;
        logic k2;
        start();
        xfer({a, 1'h0}, r, k0);
        xfer(rg, r, k1);
        xfer(d, r, k2);
        stop();
        ok = k0 && k1 && k2;
    endtask
    // Pointer, repeated start, one byte read and closed with a missing ack.
    task automatic rd(input logic [7:0] rg, output logic [7:0] d);
        logic [7:0] r;
        logic k;
        start();
        xfer({7'h2d, 1'h0}, r, k);
        xfer(rg, r, k);
        start();
        xfer({7'h2d, 1'h1}, r, k);
        xfer(8'hff, d, k);
        stop();
    endtask
endmodule

//--- test/pcr_bank_test.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: The host model drives the serial pins.
// Notes: The hold span is cut down to keep the run short.
`timescale 1ns/1ps
module pcr_bank_test;
    localparam int HOLD = 8000;
    // Offset, reset value and writable bits, in regs_o order.
    localparam logic [7:0] OFF [11] = '{8'h01, 8'h19, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    localparam logic [7:0] RST [11] = '{8'h01, 8'h20, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MSK [11] = '{8'h01, 8'hef, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hdf, 8'hdf, 8'h1f};
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] st [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    wire [7:0] regs_o [11];
    wire conv_on;
    wire scl;
    wire host_low;
    wire sda_out;
    wire sda_oe;
    // Pull-up: the line is low while either party pulls it.
    wire sda_line = (host_low || (sda_oe && !sda_out)) ? 1'h0 : 1'h1;
    int err_total = 0;
    int checked = 0;
    logic [7:0] exp_q [$];
    logic [7:0] obs;
    event got;
    assign regs_o[0] = {7'h00, conv_on};
    always #2.5 mclk = ~mclk;
    pcr_bank #(.HOLD_CYCLES(HOLD)) dut (.mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .health_status(st[0]), .die_temp(st[1]), .ain0_result(st[2]),
        .ain1_result(st[3]), .converter_on_q(conv_on), .aux_voltage_q(regs_o[2]), .channel1_voltage_q(regs_o[3]),
        .channel2_voltage_q(regs_o[4]), .channel3_voltage_q(regs_o[5]), .channel4_voltage_q(regs_o[6]),
        .group_select_q(regs_o[7]), .aux_group_on_q(regs_o[8]), .good_pin_one_route_q(regs_o[9]),
        .good_pin_two_route_q(regs_o[10]), .fault_rate_q(regs_o[1]));
    pcr_host #(.Q(16)) host (.mclk(mclk), .sda(sda_line), .scl(scl), .sda_low(host_low));
    // The driver notes the expectation, then hands the result to the monitor.
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        exp_q.push_back(e);
        @(negedge mclk);
        obs = g;
        -> got;
    endtask
    // Monitor: each result is compared with the oldest note.
    always @(got) begin
        checked++;
        if (obs !== exp_q[0]) begin
            $display("mismatch at %0t: got %h expected %h", $time, obs, exp_q[0]);
            err_total++;
        end
        void'(exp_q.pop_front());
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog sized for about 83k cycles of traffic, with some margin.
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        finish_test();
    end
    initial begin
        logic ok;
        logic [7:0] v;
        logic [7:0] wd [11];
        void'($urandom(32'h1343));
        repeat (8) @(negedge mclk);
        resetn = 1'h1;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 11; i++) chk(RST[i], regs_o[i]);
        $display("test reset_values done");
        // The rate code goes in second, before any aux enable is written.
        for (int i = 0; i < 11; i++) begin
            wd[i] = 8'($urandom);
            host.wr(7'h2d, OFF[i], wd[i], ok);
            chk(8'h01, {7'h00, ok});
            chk(wd[i] & MSK[i], regs_o[i]);
            host.rd(OFF[i], v);
            chk(wd[i] & MSK[i], v);
        end
        $display("test write_read done");
        // A neighbouring address must be ignored and change nothing.
        host.wr(7'h2d ^ 7'(1 << ($urandom % 7)), 8'h15, 8'($urandom), ok);
        chk(8'h00, {7'h00, ok});
        chk(wd[7] & MSK[7], regs_o[7]);
        $display("test wrong_address done");
        repeat (HOLD) @(negedge mclk);
        host.wr(7'h2d, 8'h13, 8'h3c, ok);
        chk(8'h01, {7'h00, ok});
        host.wr(7'h2d, 8'h14, 8'hc3, ok);
        chk(8'h01, {7'h00, ok});
        host.wr(7'h2d, 8'h13, 8'h5a, ok);
        chk(8'h00, {7'h00, ok});
        chk(8'h3c, regs_o[5]);
        // The host keeps its spacing before trying again.
        repeat (HOLD) @(negedge mclk);
        host.wr(7'h2d, 8'h13, 8'h5a, ok);
        chk(8'h5a, regs_o[5]);
        $display("test rewrite_hold done");
        for (int i = 0; i < 4; i++) begin
            st[i] = 8'($urandom);
            host.rd(8'(8'h1a + i), v);
            chk(st[i], v);
        end
        $display("test status_read done");
        finish_test();
    end
endmodule
bind pcr_bank pcr_bank_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk_i (.mclk(mclk), .resetn(resetn),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .converter_on_q(converter_on_q),
    .aux_voltage_q(aux_voltage_q), .channel1_voltage_q(channel1_voltage_q), .channel2_voltage_q(channel2_voltage_q),
    .channel3_voltage_q(channel3_voltage_q), .channel4_voltage_q(channel4_voltage_q),
    .group_select_q(group_select_q), .aux_group_on_q(aux_group_on_q), .good_pin_one_route_q(good_pin_one_route_q),
    .good_pin_two_route_q(good_pin_two_route_q), .fault_rate_q(fault_rate_q));
